// >>> rtl/swid_consts.svh
`ifndef SWID_CONSTS_SVH
`define SWID_CONSTS_SVH
// register offsets in the linear space
`define SWID_ADR_FAMILY 8'h00
`define SWID_ADR_CHIP 8'h01
`define SWID_ADR_GC0 8'h02
// field positions
`define SWID_RUN_BIT 0
`define SWID_BACKOFF_BIT 7
`define SWID_SOFT_BIT 6
`define SWID_FLDYN_BIT 5
`define SWID_FLSTA_BIT 4
`define SWID_PAUSE_BIT 1
`define SWID_LNKAGE_BIT 0
// reset values
`define SWID_RUN_RST 1'b1
`define SWID_GC0_RSVD 2'h3
// serial command bytes
`define SWID_CMD_WR 8'h02
`define SWID_CMD_RD 8'h03
// pause-type frame identifiers
`define SWID_PAUSE_TL 16'h8808
`define SWID_PAUSE_DA 48'h0180c2000001
// timing
`define SWID_CLK_MHZ 100
`define SWID_FAST_AGE_US 800
`define SWID_NORM_AGE_S 300
`define SWID_MS_US 1000
`endif

// >>> rtl/swid_pkg.sv
package swid_pkg;
  // serial frame phases
  typedef enum logic [3:0] {
    SP_IDLE = 4'b0001,
    SP_CMD = 4'b0010,
    SP_ADR = 4'b0100,
    SP_DAT = 4'b1000
  } swid_spi_st_t;
endpackage

// >>> rtl/swid_spi_slave.sv
`timescale 1ns/1ps
`include "swid_consts.svh"
module swid_spi_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial pins
  input wire logic scs_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // register access
  output logic [7:0] adr_o,
  output logic [7:0] wdat_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdat_i
);
  logic [2:0] cs_s_r;
  logic [2:0] ck_s_r;
  logic [1:0] mo_s_r;
  logic active;
  logic rise;
  logic fall;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] byte_nxt;
  logic wr_mode_r;
  logic [7:0] tx_r;
  swid_pkg::swid_spi_st_t st_r;

  // two-stage synchronisers, third stage only for edge detect
  always_ff @(posedge clk_i) begin
    cs_s_r <= {cs_s_r[1:0], scs_n_i};
    ck_s_r <= {ck_s_r[1:0], sclk_i};
    mo_s_r <= {mo_s_r[0], mosi_i};
  end

  assign active = ~cs_s_r[1];
  assign rise = ck_s_r[1] & ~ck_s_r[2];
  assign fall = ~ck_s_r[1] & ck_s_r[2];
  assign byte_nxt = {sh_r[6:0], mo_s_r[1]};

  // bit counter and receive shifter
  always_ff @(posedge clk_i) begin
    if (reset_i || !active) begin
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
    end else if (rise) begin
      cnt_r <= cnt_r + 3'h1;
      sh_r <= byte_nxt;
    end
  end

  // frame phase, address and strobes
  always_ff @(posedge clk_i) begin
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    if (reset_i) begin
      st_r <= swid_pkg::SP_CMD;
      wr_mode_r <= 1'b0;
      adr_o <= 8'h00;
      wdat_o <= 8'h00;
    end else if (!active) begin
      st_r <= swid_pkg::SP_CMD;
    end else begin
      if (wr_o) begin
        adr_o <= adr_o + 8'h01; // burst writes walk upward
      end
      if (rise && cnt_r == 3'h7) begin
        unique case (st_r)
          swid_pkg::SP_CMD: begin
            wr_mode_r <= byte_nxt == `SWID_CMD_WR;
            if (byte_nxt == `SWID_CMD_WR || byte_nxt == `SWID_CMD_RD) begin
              st_r <= swid_pkg::SP_ADR;
            end else begin
              st_r <= swid_pkg::SP_IDLE; // unknown command: rest ignored
            end
          end
          swid_pkg::SP_ADR: begin
            adr_o <= byte_nxt;
            st_r <= swid_pkg::SP_DAT;
            rd_o <= ~wr_mode_r;
          end
          swid_pkg::SP_DAT: begin
            if (wr_mode_r) begin
              wr_o <= 1'b1;
              wdat_o <= byte_nxt;
            end else begin
              adr_o <= adr_o + 8'h01;
              rd_o <= 1'b1; // prefetch next byte of the burst
            end
          end
          swid_pkg::SP_IDLE: st_r <= swid_pkg::SP_IDLE;
        endcase
      end
    end
  end

  // transmit shifter, new byte is presented before its first rise
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_r <= 8'h00;
    end else if (rd_o) begin
      tx_r <= rdat_i;
    end else if (fall && active && cnt_r != 3'h0) begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  // drive the data pin only during the read data phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      miso_oe_o <= 1'b0;
    end else begin
      miso_oe_o <= active && !wr_mode_r && st_r == swid_pkg::SP_DAT;
    end
  end
  assign miso_o = tx_r[7];
endmodule

// >>> rtl/swid_age_timer.sv
`timescale 1ns/1ps
module swid_age_timer #(
  parameter int MS_CYC = 100000,
  parameter int AGE_MS = 300000,
  parameter int FAST_CYC = 79999
) (
  // clock and core reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control and link state
  input wire logic fast_en_i,
  input wire logic [4:0] link_up_i,
  // aging events
  output logic age_tick_o,
  output logic age_all_o,
  output logic fast_busy_o
);
  localparam int MW = $clog2(MS_CYC);
  localparam int AW = $clog2(AGE_MS);
  localparam int FW = $clog2(FAST_CYC);
  logic [4:0] link_q_r;
  logic [MW-1:0] ms_cnt_r;
  logic [AW-1:0] age_cnt_r;
  logic [FW-1:0] fcnt_r;
  logic ms_tick;
  logic link_drop;

  assign ms_tick = ms_cnt_r == MW'(MS_CYC - 1);
  assign link_drop = |(link_q_r & ~link_up_i);

  // link history, cleared so release never looks like a drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_q_r <= 5'h00;
    end else begin
      link_q_r <= link_up_i;
    end
  end

  // millisecond prescaler keeps the long count narrow
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + MW'(1);
    end
  end

  // normal age period, restarted after a fast cycle
  always_ff @(posedge clk_i) begin
    age_tick_o <= 1'b0;
    if (rst_i || age_all_o) begin
      age_cnt_r <= '0;
    end else if (ms_tick) begin
      if (age_cnt_r == AW'(AGE_MS - 1)) begin
        age_cnt_r <= '0;
        age_tick_o <= 1'b1;
      end else begin
        age_cnt_r <= age_cnt_r + AW'(1);
      end
    end
  end

  // one accelerated age cycle per link loss
  always_ff @(posedge clk_i) begin
    age_all_o <= 1'b0;
    if (rst_i) begin
      fast_busy_o <= 1'b0;
      fcnt_r <= '0;
    end else if (fast_busy_o) begin
      if (fcnt_r == FW'(FAST_CYC - 1)) begin
        fast_busy_o <= 1'b0;
        age_all_o <= 1'b1;
      end else begin
        fcnt_r <= fcnt_r + FW'(1);
      end
    end else if (link_drop && fast_en_i) begin
      fast_busy_o <= 1'b1;
      fcnt_r <= '0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_fast_start;
    link_drop && fast_en_i && !fast_busy_o |=> fast_busy_o;
  endproperty
  a_fast_start: assert property (p_fast_start)
    else $error("fast aging did not start on link loss");

  property p_age_all_cause;
    age_all_o |-> $past(fast_busy_o) && !fast_busy_o;
  endproperty
  a_age_all_cause: assert property (p_age_all_cause)
    else $error("age-out without a fast age cycle");
endmodule

// >>> rtl/swid_global_ctrl.sv
`timescale 1ns/1ps
`include "swid_consts.svh"
// Operation
// - identification fields are read-only constants
// - run bit resets to one, zero halts
// - bit seven selects alternative back-off
// - soft reset holds engines, keeps configuration
// - soft reset stops reception, registers retained; the code clears both flush trigger bits
// - writing one starts dynamic flush, self-clearing
// - dynamic flush hits learning-disabled ports only
// - writing one starts static flush, self-clearing
// - static match: unicast, one learning-off port
// - policy one drops 8808 or pause address
// - policy zero drops flow-control frames only
// - link loss triggers one fast age cycle
// - fast cycle ages out every learned address
// - reserved bits read one, host leaves them
// - whole linear space reachable over serial port
module swid_global_ctrl #(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
  parameter logic [3:0] CHIP_CODE = 4'h3, // arbitrary value
  parameter logic [2:0] REV_CODE = 3'h1, // arbitrary value
  parameter int MS_CYC = `SWID_MS_US * `SWID_CLK_MHZ,
  parameter int AGE_MS = `SWID_NORM_AGE_S * 1000,
  parameter int FAST_CYC = `SWID_FAST_AGE_US * `SWID_CLK_MHZ - 1
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  // serial management pins
  input wire logic SPI_CS_N_I,
  input wire logic SPI_SCLK_I,
  input wire logic SPI_MOSI_I,
  output logic SPI_MISO_O,
  output logic SPI_MISO_OE_O,
  // core control
  output logic SWITCH_RUN_O,
  output logic BACKOFF_ALT_O,
  output logic CORE_RST_O,
  input wire logic [4:0] LEARN_DIS_I,
  input wire logic [4:0] LINK_UP_I,
  // flush handshakes
  output logic FLUSH_DYN_REQ_O,
  input wire logic FLUSH_DYN_DONE_I,
  output logic FLUSH_STA_REQ_O,
  input wire logic FLUSH_STA_DONE_I,
  // dynamic entry check
  input wire logic DYN_VALID_I,
  input wire logic [2:0] DYN_PORT_I,
  output logic DYN_MATCH_O,
  // static entry check
  input wire logic STA_VALID_I,
  input wire logic [47:0] STA_DA_I,
  input wire logic [4:0] STA_PORTS_I,
  output logic STA_MATCH_O,
  // frame drop check
  input wire logic FRM_VALID_I,
  input wire logic [15:0] FRM_TYPE_I,
  input wire logic [47:0] FRM_DA_I,
  input wire logic FRM_FC_I,
  output logic FRM_DROP_O,
  output logic FRM_DROP_VLD_O,
  // aging events
  output logic AGE_TICK_O,
  output logic AGE_ALL_O,
  output logic FAST_AGE_O
);
  logic [7:0] adr;
  logic [7:0] wdat;
  logic wr;
  logic rd;
  logic [7:0] rdat;
  logic wr_chip;
  logic wr_gc0;
  logic core_rst;
  logic run_r;
  logic backoff_r;
  logic soft_r;
  logic fdyn_r;
  logic fsta_r;
  logic pause_r;
  logic lnkage_r;

  // learning-off test for a port index
  function automatic logic learn_off(input logic [2:0] port,
                                     input logic [4:0] dis);
    learn_off = port < 3'h5 && dis[port];
  endfunction

  // exactly one bit set in a port set
  function automatic logic one_port(input logic [4:0] ports);
    one_port = ports != 5'h00 && (ports & (ports - 5'h01)) == 5'h00;
  endfunction

  // pause-type frame by type field or reserved address
  function automatic logic is_pause(input logic [15:0] tl,
                                    input logic [47:0] da);
    is_pause = tl == `SWID_PAUSE_TL || da == `SWID_PAUSE_DA;
  endfunction

  swid_spi_slave u_spi (
    .clk_i(CLK_SYS_I),
    .reset_i(RESET_I),
    .scs_n_i(SPI_CS_N_I),
    .sclk_i(SPI_SCLK_I),
    .mosi_i(SPI_MOSI_I),
    .miso_o(SPI_MISO_O),
    .miso_oe_o(SPI_MISO_OE_O),
    .adr_o(adr),
    .wdat_o(wdat),
    .wr_o(wr),
    .rd_o(rd),
    .rdat_i(rdat)
  );

  // write decode; other offsets belong to other banks
  assign wr_chip = wr && adr == `SWID_ADR_CHIP;
  assign wr_gc0 = wr && adr == `SWID_ADR_GC0;
  // engines see reset while the soft reset bit stands
  assign core_rst = RESET_I || soft_r;

  // read mux over the whole linear space
  always_comb begin
    unique case (adr)
      `SWID_ADR_FAMILY: rdat = FAMILY_CODE;
      `SWID_ADR_CHIP: rdat = {CHIP_CODE, REV_CODE, run_r};
      `SWID_ADR_GC0: rdat = {backoff_r, soft_r, fdyn_r, fsta_r,
                             `SWID_GC0_RSVD, pause_r, lnkage_r};
      default: rdat = 8'h00;
    endcase
  end

  // run bit; identification fields ignore writes
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      run_r <= `SWID_RUN_RST;
    end else if (wr_chip) begin
      run_r <= wdat[`SWID_RUN_BIT];
    end
  end

  // configuration bits, untouched by soft reset
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      backoff_r <= 1'b0;
      soft_r <= 1'b0;
      pause_r <= 1'b0;
      lnkage_r <= 1'b0;
    end else if (wr_gc0) begin
      backoff_r <= wdat[`SWID_BACKOFF_BIT];
      soft_r <= wdat[`SWID_SOFT_BIT];
      pause_r <= wdat[`SWID_PAUSE_BIT];
      lnkage_r <= wdat[`SWID_LNKAGE_BIT];
    end
  end

  // dynamic flush trigger: a written one beats the done pulse
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      fdyn_r <= 1'b0;
    end else if (wr_gc0 && wdat[`SWID_FLDYN_BIT]) begin
      fdyn_r <= 1'b1;
    end else if (FLUSH_DYN_DONE_I || soft_r) begin
      fdyn_r <= 1'b0;
    end
  end

  // static flush trigger, same discipline
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      fsta_r <= 1'b0;
    end else if (wr_gc0 && wdat[`SWID_FLSTA_BIT]) begin
      fsta_r <= 1'b1;
    end else if (FLUSH_STA_DONE_I || soft_r) begin
      fsta_r <= 1'b0;
    end
  end

  // control outputs from flops; run is gated by soft reset
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      SWITCH_RUN_O <= 1'b0;
      BACKOFF_ALT_O <= 1'b0;
      CORE_RST_O <= 1'b1;
    end else begin
      SWITCH_RUN_O <= run_r && !soft_r;
      BACKOFF_ALT_O <= backoff_r;
      CORE_RST_O <= core_rst;
    end
  end
  assign FLUSH_DYN_REQ_O = fdyn_r;
  assign FLUSH_STA_REQ_O = fsta_r;

  // entry checks only answer while their flush runs
  always_ff @(posedge CLK_SYS_I) begin
    if (core_rst) begin
      DYN_MATCH_O <= 1'b0;
      STA_MATCH_O <= 1'b0;
    end else begin
      DYN_MATCH_O <= fdyn_r && DYN_VALID_I
                     && learn_off(DYN_PORT_I, LEARN_DIS_I);
      STA_MATCH_O <= fsta_r && STA_VALID_I && !STA_DA_I[40]
                     && one_port(STA_PORTS_I)
                     && (STA_PORTS_I & LEARN_DIS_I) != 5'h00;
    end
  end

  // drop verdict, one cycle after the frame header
  always_ff @(posedge CLK_SYS_I) begin
    if (core_rst) begin
      FRM_DROP_O <= 1'b0;
      FRM_DROP_VLD_O <= 1'b0;
    end else begin
      FRM_DROP_VLD_O <= FRM_VALID_I;
      if (pause_r) begin
        FRM_DROP_O <= FRM_VALID_I
                      && is_pause(FRM_TYPE_I, FRM_DA_I);
      end else begin
        FRM_DROP_O <= FRM_VALID_I && FRM_FC_I;
      end
    end
  end

  // aging runs on the core reset so soft reset stops it
  swid_age_timer #(
    .MS_CYC(MS_CYC),
    .AGE_MS(AGE_MS),
    .FAST_CYC(FAST_CYC)
  ) u_age (
    .clk_i(CLK_SYS_I),
    .rst_i(core_rst),
    .fast_en_i(lnkage_r),
    .link_up_i(LINK_UP_I),
    .age_tick_o(AGE_TICK_O),
    .age_all_o(AGE_ALL_O),
    .fast_busy_o(FAST_AGE_O)
  );

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);

  property p_family_ro;
    rd && adr == `SWID_ADR_FAMILY |-> rdat == FAMILY_CODE;
  endproperty
  a_family_ro: assert property (p_family_ro)
    else $error("family code read wrong");

  property p_run_halt;
    wr_chip && !wdat[`SWID_RUN_BIT] |=> ##1 !SWITCH_RUN_O;
  endproperty
  a_run_halt: assert property (p_run_halt)
    else $error("switch still runs after stop");

  property p_soft_hold;
    soft_r |=> CORE_RST_O && !FRM_DROP_VLD_O && !FAST_AGE_O;
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("engines not held in soft reset");

  property p_soft_keeps;
    soft_r && !wr |=> $stable(pause_r) && $stable(run_r);
  endproperty
  a_soft_keeps: assert property (p_soft_keeps)
    else $error("configuration lost in soft reset");

  property p_dyn_start;
    wr_gc0 && wdat[`SWID_FLDYN_BIT] |=> FLUSH_DYN_REQ_O;
  endproperty
  a_dyn_start: assert property (p_dyn_start)
    else $error("dynamic flush did not start");

  // done may come any cycle, so the hold is checked step by step
  property p_dyn_hold;
    FLUSH_DYN_REQ_O && !FLUSH_DYN_DONE_I && !soft_r |=> FLUSH_DYN_REQ_O;
  endproperty
  a_dyn_hold: assert property (p_dyn_hold)
    else $error("dynamic flush not held until done");

  property p_sta_clear;
    fsta_r && FLUSH_STA_DONE_I && !(wr_gc0 && wdat[`SWID_FLSTA_BIT])
      |=> !FLUSH_STA_REQ_O;
  endproperty
  a_sta_clear: assert property (p_sta_clear)
    else $error("static flush bit did not self-clear");

  property p_pause_drop;
    !core_rst && pause_r && FRM_VALID_I && FRM_TYPE_I == `SWID_PAUSE_TL
      |=> FRM_DROP_O && FRM_DROP_VLD_O;
  endproperty
  a_pause_drop: assert property (p_pause_drop)
    else $error("pause-type frame not dropped");

  property p_fc_only;
    !core_rst && !pause_r && FRM_VALID_I && !FRM_FC_I |=> !FRM_DROP_O;
  endproperty
  a_fc_only: assert property (p_fc_only)
    else $error("non flow-control frame dropped");

  property p_rsvd_one;
    rd && adr == `SWID_ADR_GC0 |-> rdat[3:2] == `SWID_GC0_RSVD;
  endproperty
  a_rsvd_one: assert property (p_rsvd_one)
    else $error("reserved bits not read as one");

  property p_sta_multi;
    !core_rst && fsta_r && STA_VALID_I && STA_DA_I[40]
      |=> !STA_MATCH_O;
  endproperty
  a_sta_multi: assert property (p_sta_multi)
    else $error("multicast static entry matched");
endmodule

// >>> tb/swid_spi_host.sv
`timescale 1ns/1ps
// host processor on the serial management port, mode 0, msb first
module swid_spi_host (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic scs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i
);
  int hp = 8; // sclk half period in clk cycles, never below 6

  // parked: deselected, serial clock low between frames
  initial begin
    scs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // one frame: command, address, data; any offset may be named
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] adr,
      input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] sh;
    sh = {cmd, adr, wd};
    rd = 8'h00;
    // reserved control bits always written back as ones
    if (cmd == 8'h02 && adr == 8'h02)
      sh[3:2] = 2'b11;
    @(posedge clk_i);
    scs_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi_o <= sh[i];
      repeat (hp) @(posedge clk_i);
      sclk_o <= 1'b1;
      if (i < 8) begin
        rd = {rd[6:0], miso_i};
      end
      repeat (hp) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (hp) @(posedge clk_i);
    scs_n_o <= 1'b1;
    mosi_o <= ~sh[0]; // released line must not repeat the last bit
    repeat (6) @(posedge clk_i); // gap above the 4 cycle minimum
  endtask
endmodule

// >>> tb/swid_global_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "swid_consts.svh"
module swid_global_ctrl_tb_top;
  localparam int FAST_CYC = 8;
  localparam logic [7:0] FAM = 8'h3c; // arbitrary value
  localparam logic [3:0] CHIP = 4'h6; // arbitrary value
  localparam logic [2:0] REV = 3'h5; // arbitrary value
  logic clk;
  logic rst = 1'b1;
  logic cs_n, sclk, mosi, miso, miso_oe;
  logic miso_bus;
  logic run, boff, core_rst, fdyn, fsta, dmatch, smatch;
  logic drop, drop_vld, age_tick, age_all, fast;
  logic [4:0] learn = 5'h00;
  logic [4:0] link = 5'h1f;
  logic dyn_done = 1'b0, sta_done = 1'b0;
  logic dvld = 1'b0, svld = 1'b0, fvld = 1'b0, ffc = 1'b0;
  logic [2:0] dport = 3'h0;
  logic [47:0] sda = 48'h0, fda = 48'h0;
  logic [4:0] sports = 5'h0;
  logic [15:0] fty = 16'h0;
  logic [7:0] rdv;
  int fail_count = 0, check_count = 0, cyc = 0, n;
  int gc0_m = 'h0c; // reference copy of control byte 0

  // short counts keep the aging run brief
  swid_global_ctrl #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP),
    .REV_CODE(REV), .MS_CYC(4), .AGE_MS(3), .FAST_CYC(FAST_CYC)) dut (
    .CLK_SYS_I(clk), .RESET_I(rst), .SPI_CS_N_I(cs_n),
    .SPI_SCLK_I(sclk), .SPI_MOSI_I(mosi), .SPI_MISO_O(miso),
    .SPI_MISO_OE_O(miso_oe), .SWITCH_RUN_O(run), .BACKOFF_ALT_O(boff),
    .CORE_RST_O(core_rst), .LEARN_DIS_I(learn), .LINK_UP_I(link),
    .FLUSH_DYN_REQ_O(fdyn), .FLUSH_DYN_DONE_I(dyn_done),
    .FLUSH_STA_REQ_O(fsta), .FLUSH_STA_DONE_I(sta_done),
    .DYN_VALID_I(dvld), .DYN_PORT_I(dport), .DYN_MATCH_O(dmatch),
    .STA_VALID_I(svld), .STA_DA_I(sda), .STA_PORTS_I(sports),
    .STA_MATCH_O(smatch), .FRM_VALID_I(fvld), .FRM_TYPE_I(fty),
    .FRM_DA_I(fda), .FRM_FC_I(ffc), .FRM_DROP_O(drop),
    .FRM_DROP_VLD_O(drop_vld), .AGE_TICK_O(age_tick),
    .AGE_ALL_O(age_all), .FAST_AGE_O(fast));

  // pull-up on the data line while the device leaves it undriven
  assign miso_bus = miso_oe ? miso : 1'b1;
  swid_spi_host host (.clk_i(clk), .scs_n_o(cs_n), .sclk_o(sclk),
    .mosi_o(mosi), .miso_i(miso_bus));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp,
      input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(`SWID_CMD_WR, a, d, rdv);
    #1;
  endtask

  task automatic wr_gc0(input int v);
    gc0_m = v | 'h0c;
    wr(`SWID_ADR_GC0, gc0_m[7:0]);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
      input string nm);
    host.xfer(`SWID_CMD_RD, a, 8'h00, rdv);
    chk(nm, exp, rdv);
  endtask

  // back-to-back entries; result of each is seen one edge later
  task automatic entries(input int kind, input int n);
    logic e, pe, pv, v, w, fc;
    int p;
    logic [47:0] da;
    logic [4:0] ps;
    logic [15:0] ty;
    pe = 1'b0;
    pv = 1'b0;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      v = (i < n);
      w = v && !gc0_m[6];
      p = $urandom % 8;
      da = 48'({$urandom, $urandom});
      if ($urandom % 2)
        da = `SWID_PAUSE_DA;
      ps = ($urandom % 2) ? 5'h01 << ($urandom % 5) : 5'($urandom);
      ty = ($urandom % 2) ? `SWID_PAUSE_TL : 16'($urandom);
      fc = 1'($urandom);
      case (kind)
        0: begin
          dvld <= v;
          dport <= p[2:0];
          e = w && gc0_m[5] && p < 5 && learn[p];
        end
        1: begin
          svld <= v;
          sda <= da;
          sports <= ps;
          e = w && gc0_m[4] && !da[40] && $onehot(ps) && (ps & learn) != 0;
        end
        default: begin
          fvld <= v;
          fda <= da;
          fty <= ty;
          ffc <= fc;
          e = gc0_m[1] ? (ty == `SWID_PAUSE_TL || da == `SWID_PAUSE_DA) : fc;
        end
      endcase
      #1;
      if (i > 0 && kind == 0)
        chk("dyn_match", pe, dmatch);
      if (i > 0 && kind == 1)
        chk("sta_match", pe, smatch);
      if (i > 0 && kind == 2)
        chk("drop_vld", pv, drop_vld);
      if (i > 0 && kind == 2 && pv)
        chk("drop", pe, drop);
      pe = e;
      pv = w;
    end
  endtask

  task automatic end_flush(input int b);
    @(posedge clk);
    if (b == 5)
      dyn_done <= 1'b1;
    else
      sta_done <= 1'b1;
    @(posedge clk);
    dyn_done <= 1'b0;
    sta_done <= 1'b0;
    #1;
    chk("flush_req", 1'b0, b == 5 ? fdyn : fsta);
    gc0_m[b] = 1'b0;
    rd_chk(`SWID_ADR_GC0, gc0_m[7:0], "gc0");
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h772bc423));
    repeat (3) @(posedge clk); // three edges fill the sync pipes
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("run", 1'b1, run);
    chk("core_rst", 1'b0, core_rst);
    chk("backoff", 1'b0, boff);
    rd_chk(`SWID_ADR_FAMILY, FAM, "family");
    rd_chk(`SWID_ADR_CHIP, {CHIP, REV, 1'b1}, "chip");
    rd_chk(`SWID_ADR_GC0, 8'h0c, "gc0");
    wr(`SWID_ADR_FAMILY, 8'h00);
    wr(`SWID_ADR_CHIP, 8'h00);
    chk("run", 1'b0, run);
    rd_chk(`SWID_ADR_FAMILY, FAM, "family");
    rd_chk(`SWID_ADR_CHIP, {CHIP, REV, 1'b0}, "chip");
    wr(`SWID_ADR_CHIP, 8'h01);
    chk("run", 1'b1, run);
    rd_chk(8'hff, 8'h00, "unmapped");
    // unknown command on a slow clock must change nothing
    host.hp = 12;
    host.xfer(8'h05, `SWID_ADR_GC0, 8'hff, rdv);
    host.hp = 6;
    chk("unknown_cmd", 8'hff, rdv);
    rd_chk(`SWID_ADR_GC0, 8'h0c, "gc0");
    wr_gc0('h80);
    chk("backoff", 1'b1, boff);
    // dynamic flush with every port's learning off, then a random set
    @(posedge clk);
    learn <= 5'h1f;
    entries(0, 6);
    wr_gc0(gc0_m | 'h20);
    chk("dyn_req", 1'b1, fdyn);
    rd_chk(`SWID_ADR_GC0, gc0_m[7:0], "gc0");
    entries(0, 12);
    @(posedge clk);
    learn <= 5'($urandom);
    entries(0, 12);
    end_flush(5);
    learn <= 5'($urandom) | 5'h04;
    entries(1, 6);
    wr_gc0(gc0_m | 'h10);
    chk("sta_req", 1'b1, fsta);
    entries(1, 24);
    end_flush(4);
    for (int pol = 0; pol < 2; pol++) begin
      wr_gc0((gc0_m & 'hfd) | (pol << 1));
      entries(2, 16);
    end
    // fast aging on link loss
    wr_gc0(gc0_m | 'h01);
    @(posedge clk);
    link <= 5'h1b;
    @(posedge clk);
    #1;
    chk("fast", 1'b1, fast);
    for (int j = 1; j <= FAST_CYC; j++) begin
      @(posedge clk);
      #1;
      chk("age_all", j == FAST_CYC, age_all);
    end
    chk("fast", 1'b0, fast);
    // tick phase after the fast cycle is free, so align on one tick
    n = 0;
    while (!age_tick && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    repeat (120) begin
      @(posedge clk);
      #1;
      n += age_tick;
    end
    chk("ticks", 8'd10, n[7:0]);
    @(posedge clk);
    link <= 5'h1f;
    wr_gc0(gc0_m & 'hfe);
    @(posedge clk);
    link <= 5'h0f;
    repeat (3) @(posedge clk);
    #1;
    chk("fast", 1'b0, fast);
    // soft reset holds the engines but keeps the registers
    wr_gc0(gc0_m | 'h40);
    chk("core_rst", 1'b1, core_rst);
    chk("run", 1'b0, run);
    rd_chk(`SWID_ADR_GC0, gc0_m[7:0], "gc0");
    entries(2, 6);
    wr_gc0(gc0_m & 'hbf);
    chk("core_rst", 1'b0, core_rst);
    chk("run", 1'b1, run);
    give_verdict();
  end
endmodule
